/* rtl/pssb_bank.sv */
`timescale 1ns/1ps
module pssb_bank
    import pssb_pkg::*;
#(
    parameter int unsigned PG_WAIT = PG_WAIT_CYCLES
) (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Status command port
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [7:0] cmd_code,
    output logic rd_valid,
    output logic [15:0] rd_data,
    output logic rd_two_bytes,
    output logic cmd_unsupported,
    output logic write_refused,
    // Output state pins
    input wire logic output_enable,
    input wire logic power_good,
    // Output-voltage fault events
    input wire logic output_overvoltage_fault,
    input wire logic output_overvoltage_warning,
    input wire logic output_undervoltage_warning,
    input wire logic output_undervoltage_fault,
    input wire logic clear_faults,
    // Target setting check
    input wire logic target_write,
    input wire logic [15:0] output_target_setting,
    input wire logic [15:0] output_ceiling_setting,
    // Other detail registers
    input wire logic [7:0] output_current_detail,
    input wire logic [7:0] input_detail,
    input wire logic [7:0] temperature_detail,
    input wire logic [7:0] comm_logic_detail,
    input wire logic [7:0] vendor_detail,
    // Live summary
    output logic [15:0] summary_word
);
    // The settle check below watches eight cycles, so shorter windows are refused
    if (PG_WAIT < 8 || PG_WAIT >= (1 << PG_CNT_W)) begin : gen_wait_check
        $error("pssb_bank: PG_WAIT out of counter range");
    end

    localparam logic [PG_CNT_W-1:0] PG_LAST = PG_CNT_W'(PG_WAIT - 1);

    typedef struct packed {
        pssb_power_type power;
        logic [PG_CNT_W-1:0] wait_cnt;
        logic [7:0] output_voltage_detail;
        logic rd_valid;
        logic [15:0] rd_data;
        logic rd_two_bytes;
        logic unsupported;
        logic refused;
    } pssb_bank_type;

    pssb_bank_type cur;
    pssb_bank_type next_cur;

    logic enable_s;
    logic pg_s;
    logic [15:0] word;
    logic any_detail;
    logic target_bad;

    // Pins cross into the controller clock
    pssb_sync #(
        .WIDTH(2)
    ) pin_sync (
        .clock(clock),
        .sys_rst(sys_rst),
        .async_in({output_enable, power_good}),
        .sync_out({enable_s, pg_s})
    );

    assign any_detail = (|cur.output_voltage_detail) | (|output_current_detail)
        | (|input_detail) | (|temperature_detail) | (|comm_logic_detail)
        | (|vendor_detail);
    assign target_bad = (output_target_setting > output_ceiling_setting)
        || (output_target_setting < TARGET_MIN_MV);

    // Summary word; the byte command reads its low half, so both share storage
    always_comb begin
        word = SUMMARY_WORD_RESET;
        word[SW_OUTPUT_VOLTAGE_SUMMARY] = |cur.output_voltage_detail;
        word[SW_OUTPUT_CURRENT_SUMMARY] = output_current_detail[ID_OC_FAULT];
        word[SW_INPUT] = |input_detail;
        word[SW_VENDOR] = |vendor_detail;
        // Supply-good is ignored while settling, since it may lag enable
        word[SW_PG_N] = !pg_s || (cur.power != PSSB_RUN);
        word[SW_OTHER] = any_detail;
        word[SW_OFF] = (cur.power == PSSB_IDLE) || !pg_s;
        word[SW_OUTPUT_VOLTAGE_SUMMARY_OV] = cur.output_voltage_detail[VD_OV_FAULT];
        word[SW_OUTPUT_CURRENT_SUMMARY_OC] = output_current_detail[ID_OC_FAULT];
        word[SW_VIN_UV] = input_detail[IN_UV_FAULT];
        word[SW_TEMP] = |temperature_detail;
        word[SW_CML] = |comm_logic_detail;
    end

    always_comb begin
        next_cur = cur;
        next_cur.rd_valid = 1'b0;
        next_cur.unsupported = 1'b0;
        next_cur.refused = 1'b0;

        // Clear first so that an event in the same cycle survives
        if (clear_faults) begin
            next_cur.output_voltage_detail = OUTPUT_VOLTAGE_SUMMARY_DETAIL_RESET;
        end
        if (output_overvoltage_fault) begin
            next_cur.output_voltage_detail[VD_OV_FAULT] = 1'b1;
        end
        if (output_undervoltage_fault) begin
            next_cur.output_voltage_detail[VD_UV_FAULT] = 1'b1;
        end
        // A warning arriving with its fault is dropped, so it may stay clear
        if (output_overvoltage_warning && !output_overvoltage_fault) begin
            next_cur.output_voltage_detail[VD_OV_WARN] = 1'b1;
        end
        if (output_undervoltage_warning && !output_undervoltage_fault) begin
            next_cur.output_voltage_detail[VD_UV_WARN] = 1'b1;
        end
        if (target_write && target_bad) begin
            next_cur.output_voltage_detail[VD_TARGET_LIMIT] = 1'b1;
        end

        // Enable tracking for the supply-good settle window
        unique case (cur.power)
            PSSB_IDLE: begin
                next_cur.wait_cnt = '0;
                if (enable_s) begin
                    next_cur.power = PSSB_SETTLE;
                end
            end
            PSSB_SETTLE: begin
                if (!enable_s) begin
                    next_cur.power = PSSB_IDLE;
                end else if (cur.wait_cnt == PG_LAST) begin
                    next_cur.power = PSSB_RUN;
                end else begin
                    next_cur.wait_cnt = cur.wait_cnt + 1'b1;
                end
            end
            PSSB_RUN: begin
                if (!enable_s) begin
                    next_cur.power = PSSB_IDLE;
                end
            end
            default: begin
                next_cur.power = PSSB_IDLE;
            end
        endcase

        // Command decode; writes never touch the status storage
        if (cmd_valid) begin
            unique case (cmd_code)
                CMD_SUMMARY_BYTE, CMD_SUMMARY_WORD, CMD_OUTPUT_VOLTAGE_SUMMARY_DETAIL: begin
                    if (cmd_write) begin
                        next_cur.refused = 1'b1;
                    end else begin
                        next_cur.rd_valid = 1'b1;
                        next_cur.rd_two_bytes = (cmd_code == CMD_SUMMARY_WORD);
                        if (cmd_code == CMD_SUMMARY_BYTE) begin
                            next_cur.rd_data = {8'h00, word[7:0]};
                        end else if (cmd_code == CMD_SUMMARY_WORD) begin
                            next_cur.rd_data = word;
                        end else begin
                            next_cur.rd_data = {8'h00, cur.output_voltage_detail};
                        end
                    end
                end
                default: begin
                    next_cur.unsupported = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            cur.power <= PSSB_IDLE;
            cur.wait_cnt <= '0;
            cur.output_voltage_detail <= OUTPUT_VOLTAGE_SUMMARY_DETAIL_RESET;
            cur.rd_valid <= 1'b0;
            cur.rd_data <= SUMMARY_WORD_RESET;
            cur.rd_two_bytes <= 1'b0;
            cur.unsupported <= 1'b0;
            cur.refused <= 1'b0;
        end else begin
            cur <= next_cur;
        end
    end

    assign rd_valid = cur.rd_valid;
    assign rd_data = cur.rd_data;
    assign rd_two_bytes = cur.rd_two_bytes;
    assign cmd_unsupported = cur.unsupported;
    assign write_refused = cur.refused;
    assign summary_word = word;

    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    logic rd_cmd;
    assign rd_cmd = cmd_valid && !cmd_write;

    AST_BYTE_SHARED: assert property (
        rd_cmd && cmd_code == CMD_SUMMARY_BYTE |=> rd_valid && !rd_two_bytes
            && rd_data == {8'h00, $past(word[7:0])})
        else $error("summary byte differs from word low byte");
    AST_WORD_READ: assert property (
        rd_cmd && cmd_code == CMD_SUMMARY_WORD |=> rd_valid && rd_two_bytes
            && rd_data == $past(word))
        else $error("summary word read wrong");
    AST_OFF_BIT: assert property (
        !enable_s |=> summary_word[SW_OFF])
        else $error("off bit clear while disabled");
    AST_OV_FAULT: assert property (
        output_overvoltage_fault |=> summary_word[SW_OUTPUT_VOLTAGE_SUMMARY_OV] && summary_word[SW_OUTPUT_VOLTAGE_SUMMARY])
        else $error("overvoltage fault not summarised");
    AST_OC_FAULT: assert property (
        output_current_detail[ID_OC_FAULT] |-> summary_word[SW_OUTPUT_CURRENT_SUMMARY_OC]
            && summary_word[SW_OUTPUT_CURRENT_SUMMARY])
        else $error("overcurrent fault not summarised");
    AST_VIN_UV: assert property (
        input_detail[IN_UV_FAULT] |-> summary_word[SW_VIN_UV] && summary_word[SW_INPUT])
        else $error("input undervoltage not summarised");
    AST_TEMP: assert property (
        summary_word[SW_TEMP] == (|temperature_detail))
        else $error("temperature summary mismatch");
    AST_CML: assert property (
        summary_word[SW_CML] == (|comm_logic_detail))
        else $error("comm logic summary mismatch");
    AST_VENDOR: assert property (
        summary_word[SW_VENDOR] == (|vendor_detail))
        else $error("vendor summary mismatch");
    AST_PG_NEGATED: assert property (
        !pg_s |-> summary_word[SW_PG_N])
        else $error("supply-good bit clear while negated");
    AST_PG_SETTLE: assert property (
        $rose(cur.power == PSSB_SETTLE) |-> summary_word[SW_PG_N] [*8])
        else $error("supply-good bit cleared inside settle window");
    AST_OTHER: assert property (
        (|comm_logic_detail) || (|cur.output_voltage_detail) || (|output_current_detail)
            || (|input_detail) || (|temperature_detail) || (|vendor_detail)
            |-> summary_word[SW_OTHER])
        else $error("other bit clear with detail set");
    AST_OUTPUT_VOLTAGE_SUMMARY_READ: assert property (
        rd_cmd && cmd_code == CMD_OUTPUT_VOLTAGE_SUMMARY_DETAIL
            |=> rd_data == {8'h00, $past(cur.output_voltage_detail)})
        else $error("output voltage detail read wrong");
    AST_UV_FAULT: assert property (
        output_undervoltage_fault |=> cur.output_voltage_detail[VD_UV_FAULT])
        else $error("undervoltage fault not latched");
    AST_OV_WARN_BLOCK: assert property (
        output_overvoltage_fault && !cur.output_voltage_detail[VD_OV_WARN]
            && output_overvoltage_warning |=> !cur.output_voltage_detail[VD_OV_WARN])
        else $error("overvoltage warning set by fault");
    AST_UV_WARN_BLOCK: assert property (
        output_undervoltage_warning && output_undervoltage_fault
            && !cur.output_voltage_detail[VD_UV_WARN]
            |=> !cur.output_voltage_detail[VD_UV_WARN])
        else $error("undervoltage warning set with fault");
    AST_TARGET_LIMIT: assert property (
        target_write && (output_target_setting < TARGET_MIN_MV
            || output_target_setting > output_ceiling_setting)
            |=> cur.output_voltage_detail[VD_TARGET_LIMIT])
        else $error("target limit not flagged");
    AST_UNUSED_ZERO: assert property (
        summary_word[10] == 1'b0 && summary_word[8:7] == 2'b00 && summary_word[0] == 1'b0
            && cur.output_voltage_detail[2:0] == 3'h0)
        else $error("unused bit set");
    AST_WRITE_KEEP: assert property (
        cmd_valid && cmd_write && cmd_code == CMD_OUTPUT_VOLTAGE_SUMMARY_DETAIL && !clear_faults
            && !output_overvoltage_fault && !output_undervoltage_fault
            && !output_overvoltage_warning && !output_undervoltage_warning && !target_write
            |=> write_refused && $stable(cur.output_voltage_detail))
        else $error("status write changed contents");
endmodule : pssb_bank

/* rtl/pssb_pkg.sv */
package pssb_pkg;
    localparam logic [7:0] CMD_SUMMARY_BYTE = 8'h78;
    localparam logic [7:0] CMD_SUMMARY_WORD = 8'h79;
    localparam logic [7:0] CMD_OUTPUT_VOLTAGE_SUMMARY_DETAIL = 8'h7A;
    localparam logic [7:0] SUMMARY_BYTE_RESET = 8'h00;
    localparam logic [15:0] SUMMARY_WORD_RESET = 16'h0000;
    localparam logic [7:0] OUTPUT_VOLTAGE_SUMMARY_DETAIL_RESET = 8'h00;
    // Summary word fields
    localparam int unsigned SW_CML = 1;
    localparam int unsigned SW_TEMP = 2;
    localparam int unsigned SW_VIN_UV = 3;
    localparam int unsigned SW_OUTPUT_CURRENT_SUMMARY_OC = 4;
    localparam int unsigned SW_OUTPUT_VOLTAGE_SUMMARY_OV = 5;
    localparam int unsigned SW_OFF = 6;
    localparam int unsigned SW_OTHER = 9;
    localparam int unsigned SW_PG_N = 11;
    localparam int unsigned SW_VENDOR = 12;
    localparam int unsigned SW_INPUT = 13;
    localparam int unsigned SW_OUTPUT_CURRENT_SUMMARY = 14;
    localparam int unsigned SW_OUTPUT_VOLTAGE_SUMMARY = 15;
    // Output-voltage detail fields
    localparam int unsigned VD_OV_FAULT = 7;
    localparam int unsigned VD_OV_WARN = 6;
    localparam int unsigned VD_UV_WARN = 5;
    localparam int unsigned VD_UV_FAULT = 4;
    localparam int unsigned VD_TARGET_LIMIT = 3;
    // Other detail fields used by the summary
    localparam int unsigned ID_OC_FAULT = 7;
    localparam int unsigned IN_UV_FAULT = 4;
    // Target setting is in millivolts; lower limit 0.1V
    localparam logic [15:0] TARGET_MIN_MV = 16'h0064;
    // Supply-good settle window after enable
    localparam int unsigned CLOCK_HZ = 50_000_000;
    localparam int unsigned PG_WAIT_US = 2000;
    localparam int unsigned PG_WAIT_CYCLES = PG_WAIT_US * (CLOCK_HZ / 1_000_000);
    localparam int unsigned PG_CNT_W = 17;
    typedef enum logic [2:0] {
        PSSB_IDLE = 3'h1,
        PSSB_SETTLE = 3'h2,
        PSSB_RUN = 3'h4
    } pssb_power_type;
endpackage : pssb_pkg

/* rtl/pssb_sync.sv */
`timescale 1ns/1ps
module pssb_sync
    import pssb_pkg::*;
#(
    parameter int WIDTH = 2
) (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    if (WIDTH < 1) begin : gen_width_check
        $error("pssb_sync: WIDTH must be at least 1");
    end

    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } pssb_sync_type;

    pssb_sync_type cur;
    pssb_sync_type next_cur;

    // First stage feeds only the second stage
    always_comb begin
        next_cur = cur;
        for (int i = 0; i < WIDTH; i++) begin
            next_cur.stage1[i] = async_in[i];
            next_cur.stage2[i] = cur.stage1[i];
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign sync_out = cur.stage2;
endmodule : pssb_sync

/* verification/pssb_host_model.sv */
`timescale 1ns/1ps
module pssb_host_model
    import pssb_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Command side
    output logic cmd_valid,
    output logic cmd_write,
    output logic [7:0] cmd_code,
    // Answer side
    input wire logic rd_valid,
    input wire logic [15:0] rd_data,
    input wire logic rd_two_bytes,
    input wire logic cmd_unsupported,
    input wire logic write_refused
);
    initial begin
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_code = 8'h00;
    end
    // One command per call; the answer stands for the single cycle after the taking edge
    task automatic xfer(input logic wr, input logic [7:0] code, output logic [15:0] data,
        output logic [3:0] flags);
        @(posedge clock);
        cmd_valid <= 1'b1;
        cmd_write <= wr;
        cmd_code <= code;
        @(posedge clock);
        cmd_valid <= 1'b0;
        // Idle qualifiers flip, so a design that ignores the strobe sees garbage
        cmd_write <= ~wr;
        cmd_code <= ~code;
        #1;
        data = rd_data;
        flags = {rd_valid, rd_two_bytes, cmd_unsupported, write_refused};
    endtask : xfer
endmodule : pssb_host_model

/* verification/pssb_bank_tb_top.sv */
`timescale 1ns/1ps
module pssb_bank_tb_top
    import pssb_pkg::*;
;
    localparam int unsigned PGW = 16;
    logic clock, sys_rst, cmd_valid, cmd_write, rd_valid, rd_two_bytes;
    logic cmd_unsupported, write_refused, oe, pg, ovf, ovw, uvw, uvf, clr, tw;
    logic [7:0] cmd_code, oc_d, in_d, tp_d, cm_d, vn_d;
    logic [15:0] rd_data, summary_word, tgt, ceil;
    int n_errors = 0;
    int check_count = 0;
    logic [4:0] ev_tab [9] = '{5'h08, 5'h10, 5'h0C, 5'h10, 5'h03, 5'h10, 5'h06, 5'h19, 5'h10};
    logic [7:0] vd_tab [9] = '{8'h80, 8'h00, 8'h80, 8'h00, 8'h10, 8'h00, 8'h60, 8'h90, 8'h00};
    logic [15:0] tg_tab [8] = '{16'h0063, 16'h0000, 16'h0064, 16'h1000, 16'h1001, 16'h0000,
        16'h0800, 16'h0000};
    logic [7:0] tv_tab [8] = '{8'h08, 8'h00, 8'h00, 8'h00, 8'h08, 8'h00, 8'h08, 8'h00};
    logic [39:0] det_tab [8] = '{40'h80_00_00_00_00, 40'h20_00_00_00_00, 40'h00_10_00_00_00,
        40'h00_80_00_00_00, 40'h00_00_40_00_00, 40'h00_00_00_02_00, 40'h00_00_00_00_01, 40'h0};

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    pssb_bank #(.PG_WAIT(PGW)) uut (.clock(clock), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
        .cmd_write(cmd_write), .cmd_code(cmd_code), .rd_valid(rd_valid), .rd_data(rd_data),
        .rd_two_bytes(rd_two_bytes), .cmd_unsupported(cmd_unsupported),
        .write_refused(write_refused), .output_enable(oe), .power_good(pg),
        .output_overvoltage_fault(ovf), .output_overvoltage_warning(ovw),
        .output_undervoltage_warning(uvw), .output_undervoltage_fault(uvf),
        .clear_faults(clr), .target_write(tw), .output_target_setting(tgt),
        .output_ceiling_setting(ceil), .output_current_detail(oc_d), .input_detail(in_d),
        .temperature_detail(tp_d), .comm_logic_detail(cm_d), .vendor_detail(vn_d),
        .summary_word(summary_word));

    pssb_host_model host (.clock(clock), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
        .cmd_write(cmd_write), .cmd_code(cmd_code), .rd_valid(rd_valid), .rd_data(rd_data),
        .rd_two_bytes(rd_two_bytes), .cmd_unsupported(cmd_unsupported),
        .write_refused(write_refused));

    task automatic test_done;
        if (n_errors == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : test_done

    task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_word

    // Expected word built bit by bit from the category meanings
    function automatic logic [15:0] exp_word(input logic [7:0] vd, input logic off,
        input logic pgn);
        logic [15:0] w;
        w = 16'h0000;
        w[SW_CML] = |cm_d;
        w[SW_TEMP] = |tp_d;
        w[SW_VIN_UV] = in_d[IN_UV_FAULT];
        w[SW_OUTPUT_CURRENT_SUMMARY_OC] = oc_d[ID_OC_FAULT];
        w[SW_OUTPUT_VOLTAGE_SUMMARY_OV] = vd[VD_OV_FAULT];
        w[SW_OFF] = off;
        w[SW_OTHER] = |{vd, oc_d, in_d, tp_d, cm_d, vn_d};
        w[SW_PG_N] = pgn;
        w[SW_VENDOR] = |vn_d;
        w[SW_INPUT] = |in_d;
        w[SW_OUTPUT_CURRENT_SUMMARY] = oc_d[ID_OC_FAULT];
        w[SW_OUTPUT_VOLTAGE_SUMMARY] = |vd;
        return w;
    endfunction : exp_word

    task automatic rd(input logic [7:0] code, input logic [15:0] exp, input logic two);
        logic [15:0] d;
        logic [3:0] f;
        host.xfer(1'b0, code, d, f);
        check_word({12'h000, f}, {12'h000, 1'b1, two, 2'b00});
        check_word(d, exp);
    endtask : rd

    task automatic check_all(input logic [7:0] vd, input logic off, input logic pgn);
        logic [15:0] w;
        @(posedge clock);
        #1;
        w = exp_word(vd, off, pgn);
        check_word(summary_word, w);
        rd(CMD_SUMMARY_BYTE, {8'h00, w[7:0]}, 1'b0);
        rd(CMD_SUMMARY_WORD, w, 1'b1);
        rd(CMD_OUTPUT_VOLTAGE_SUMMARY_DETAIL, {8'h00, vd}, 1'b0);
    endtask : check_all

    task automatic cmd_flags(input logic wr, input logic [7:0] code, input logic [3:0] exp);
        logic [15:0] d;
        logic [3:0] f;
        host.xfer(wr, code, d, f);
        check_word({12'h000, f[3], f[1:0]}, {12'h000, exp[3], exp[1:0]});
    endtask : cmd_flags

    task automatic pulse(input logic [4:0] ev);
        @(posedge clock);
        {clr, ovf, ovw, uvw, uvf} <= ev;
        @(posedge clock);
        {clr, ovf, ovw, uvw, uvf} <= 5'h00;
    endtask : pulse

    initial begin
        sys_rst = 1'b1;
        {oe, pg, ovf, ovw, uvw, uvf, clr, tw} = 8'h00;
        {oc_d, in_d, tp_d, cm_d, vn_d} = 40'h0;
        tgt = 16'h0000;
        ceil = 16'h1000;
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        check_all(8'h00, 1'b1, 1'b1);
        foreach (vd_tab[i]) begin
            if (i < 3) begin
                cmd_flags(1'b1, CMD_SUMMARY_BYTE + 8'(i), 4'h1);
            end
        end
        cmd_flags(1'b1, 8'h7B, 4'h2);
        cmd_flags(1'b0, 8'h7B, 4'h2);
        check_all(8'h00, 1'b1, 1'b1);
        @(posedge clock);
        {oe, pg} <= 2'b11;
        repeat (6) @(posedge clock);
        #1;
        check_word({15'h0000, summary_word[SW_PG_N]}, 16'h0001);
        repeat (PGW + 4) @(posedge clock);
        check_all(8'h00, 1'b0, 1'b0);
        @(posedge clock);
        pg <= 1'b0;
        repeat (4) @(posedge clock);
        check_all(8'h00, 1'b1, 1'b1);
        @(posedge clock);
        pg <= 1'b1;
        repeat (4) @(posedge clock);
        foreach (ev_tab[i]) begin
            pulse(ev_tab[i]);
            check_all(vd_tab[i], 1'b0, 1'b0);
        end
        foreach (tg_tab[i]) begin
            @(posedge clock);
            tw <= !(i == 1 || i == 5 || i == 7);
            tgt <= tg_tab[i];
            ceil <= (i == 6) ? 16'h07FF : 16'h1000;
            clr <= (i == 1 || i == 5 || i == 7);
            @(posedge clock);
            {tw, clr} <= 2'b00;
            check_all(tv_tab[i], 1'b0, 1'b0);
        end
        foreach (det_tab[i]) begin
            @(posedge clock);
            {oc_d, in_d, tp_d, cm_d, vn_d} <= det_tab[i];
            check_all(8'h00, 1'b0, 1'b0);
        end
        @(posedge clock);
        oe <= 1'b0;
        pulse(5'h08);
        repeat (3) @(posedge clock);
        cmd_flags(1'b1, CMD_OUTPUT_VOLTAGE_SUMMARY_DETAIL, 4'h1);
        check_all(8'h80, 1'b1, 1'b1);
        @(posedge clock);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        check_all(8'h00, 1'b1, 1'b1);
        test_done();
    end

    // Watchdog: a hung run counts as a failure
    initial begin
        #200000;
        n_errors++;
        test_done();
    end
endmodule : pssb_bank_tb_top
